/* design/pmic_state_pkg.sv */
package pmic_state_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NRAIL = 5;
    localparam int NRST = 3;
    localparam int NREG = 6;
    localparam int DCNT_W = 20;
    localparam int RETRY_W = 24;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int RETRY_TIME_MS = 100;
    localparam int RETRY_CYC = RETRY_TIME_MS * (CLK_HZ / 1000);
    localparam int DLY_UNIT_US = 100;
    localparam int DLY_UNIT_CYC = DLY_UNIT_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------
    // Register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [5:0] CTRL_IDX = 6'h00;
    localparam logic [5:0] MASK_IDX = 6'h01;
    localparam logic [5:0] RMASK_IDX = 6'h02;
    localparam logic [5:0] LP_ON_IDX = 6'h03;
    localparam logic [5:0] ON_DLY_IDX = 6'h04;
    localparam logic [5:0] OFF_DLY_IDX = 6'h05;
    localparam logic [5:0] STAT_IDX = 6'h06;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SLP_REQ_BIT = 0;
    localparam int SLP_ARM_BIT = 1;
    localparam int DP_REQ_BIT = 2;
    localparam int DP_ARM_BIT = 3;
    localparam int DP_SEL_BIT = 4;
    localparam int RF_DIS_BIT = 5;
    localparam int TH_MASK_BIT = 5;
    localparam int OV_MASK_POS = 0;
    localparam int UV_MASK_POS = 8;
    localparam int LP_ON_POS = 0;
    localparam int DP_ON_POS = 8;
    localparam int DLY_CODE_W = 4;
    localparam int ST_POS = 0;
    localparam int EN_POS = 8;
    localparam int OV_POS = 16;
    localparam int UV_POS = 24;
    localparam int TH_BIT = 30;
    localparam int PIN_BIT = 31;

    // ------------------------------------------------------------
    // Reset values and writable bits, entry i is register index i
    // ------------------------------------------------------------
    localparam logic [NREG-1:0][31:0] REG_RST = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
    localparam logic [NREG-1:0][31:0] REG_WMASK = {
        32'h000f_ffff, 32'h000f_ffff, 32'h0000_1f1f,
        32'h0000_1f1f, 32'h0000_0020, 32'h0000_003f};

    typedef enum logic [2:0] {
        ST_RESET, ST_SEQ_START, ST_ACTIVE, ST_SLEEP,
        ST_DEEP, ST_THERMAL, ST_RAIL_FAULT
    } op_state_t;

    typedef struct packed {
        logic input_power_good;
        logic thermal_fault;
        logic [NRAIL-1:0] over_voltage_fault;
        logic [NRAIL-1:0] under_voltage_fault;
        logic [NRAIL-1:0] ramp_done;
    } pmic_pins_t;

    typedef struct packed {
        op_state_t st;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic [1:0] prime;
        pmic_pins_t sy1;
        pmic_pins_t sy2;
        logic [NREG-1:0][31:0] regs;
        logic [NRAIL-1:0] en;
        logic [NRAIL-1:0][DCNT_W-1:0] dcnt;
        logic [RETRY_W-1:0] retry;
        logic rst_out;
        logic irq_n;
        logic txn_rst;
        logic ack;
        logic [31:0] rdata;
    } ctl_state_t;

endpackage

/* design/pmic_state_ctrl.sv */
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// - Light sleep needs request and arm both set
// - Leave light sleep once its condition drops
// - Rails follow light-sleep settings with delays
// - Register bus keeps working in sleep states
// - Select 0: pin low, arm, request enter deep
// - Select 1: pin low and arm enter deep
// - Every pin rise after power-up sets arm
// - Armed pin fall enters deep sleep
// - Leave deep sleep once its condition drops
// - Fault in deep sleep returns to active
// - Fault exit from deep clears arm
// - No automatic deep re-entry after fault exit
// - Separate deep-sleep rail settings with delays
// - Thermal: all rails off, resets low
// - Thermal mask gates only the interrupt
// - OV anytime, UV after ramp: rail fault
// - Rail fault retries to active after 100ms
// - Shutdown disable bit blocks rail-fault state
// - Overcurrent alone never causes rail fault
// - Rail masks gate only the interrupt
// - Reset, sequence start, then chosen state
// - Serial reset pulse on sleep or fault entry
// - Power loss: reset state, rails off, defaults
module pmic_state_ctrl #(
    parameter int unsigned RETRY_CYCLES = pmic_state_pkg::RETRY_CYC,
    parameter int unsigned DLY_UNIT = pmic_state_pkg::DLY_UNIT_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic power_enable_input,
    input wire pmic_state_pkg::pmic_pins_t pins,
    output logic [pmic_state_pkg::NRAIL-1:0] regulator_enable,
    output logic [pmic_state_pkg::NRST-1:0] reset_out_low,
    output logic interrupt_out_low,
    output logic serial_txn_reset,
    output pmic_state_pkg::op_state_t op_state
);
    import pmic_state_pkg::*;

    ctl_state_t q;
    ctl_state_t d;

    // ------------------------------------------------------------
    // Per-rail target level and sequencing delay
    // ------------------------------------------------------------
    logic [NRAIL-1:0] tgt;
    logic [NRAIL-1:0][DCNT_W-1:0] lim;

    genvar gi;
    generate
        for (gi = 0; gi < NRAIL; gi++) begin : g_rail
            logic [DLY_CODE_W-1:0] on_code;
            logic [DLY_CODE_W-1:0] off_code;
            logic [DLY_CODE_W-1:0] code;
            assign on_code = q.regs[ON_DLY_IDX][gi*DLY_CODE_W +: DLY_CODE_W];
            assign off_code = q.regs[OFF_DLY_IDX][gi*DLY_CODE_W +: DLY_CODE_W];
            assign code = q.en[gi] ? off_code : on_code;
            assign lim[gi] = DCNT_W'(code * DLY_UNIT);
            always_comb begin
                case (q.st)
                    ST_SLEEP: tgt[gi] = q.regs[LP_ON_IDX][LP_ON_POS + gi];
                    ST_DEEP: tgt[gi] = q.regs[LP_ON_IDX][DP_ON_POS + gi];
                    ST_ACTIVE, ST_SEQ_START: tgt[gi] = 1'b1;
                    default: tgt[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    logic pin;
    logic rise;
    logic th;
    logic [NRAIL-1:0] ov;
    logic [NRAIL-1:0] uv;
    logic rail_flt;
    logic flt_go;
    logic dp_go;
    logic sl_go;
    logic [5:0] idx;
    logic [31:0] bem;
    logic [31:0] stat;
    logic [31:0] rd;
    logic off_all;

    always_comb begin
        d = q;
        // Pin and fault lines are asynchronous to the core clock
        d.pin_s1 = power_enable_input;
        d.pin_s2 = q.pin_s1;
        d.sy1 = pins;
        d.sy2 = q.sy1;
        d.prime = {q.prime[0], 1'b1};
        pin = q.pin_s2;
        // Prime holds off edge detection until the chain is valid
        d.pin_prev = q.prime[1] ? pin : 1'b1;
        rise = q.prime[1] & pin & ~q.pin_prev;
        th = q.sy2.thermal_fault;
        ov = q.sy2.over_voltage_fault;
        uv = q.sy2.under_voltage_fault;
        // No overcurrent input: it only matters through its UV
        rail_flt = (|ov) | (|(uv & q.sy2.ramp_done));
        flt_go = rail_flt & ~q.regs[CTRL_IDX][RF_DIS_BIT];
        dp_go = ~pin & q.regs[CTRL_IDX][DP_ARM_BIT]
              & (q.regs[CTRL_IDX][DP_SEL_BIT] | q.regs[CTRL_IDX][DP_REQ_BIT]);
        sl_go = q.regs[CTRL_IDX][SLP_REQ_BIT] & q.regs[CTRL_IDX][SLP_ARM_BIT];

        // --------------------------------------------------------
        // Register bus, one wait cycle per access in every state
        // --------------------------------------------------------
        idx = avs_address[7:2];
        bem = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        d.ack = (avs_read | avs_write) & ~q.ack;
        stat = 32'h0000_0000;
        stat[ST_POS +: 3] = q.st;
        stat[EN_POS +: NRAIL] = q.en;
        stat[OV_POS +: NRAIL] = ov;
        stat[UV_POS +: NRAIL] = uv;
        stat[TH_BIT] = th;
        stat[PIN_BIT] = pin;
        if (idx < 6'(NREG)) begin
            rd = q.regs[idx[2:0]] & REG_WMASK[idx[2:0]];
        end else if (idx == STAT_IDX) begin
            rd = stat;
        end else begin
            rd = 32'h0000_0000;
        end
        if (avs_read & ~q.ack) begin
            d.rdata = rd;
        end
        if (avs_write & q.ack & (idx < 6'(NREG))) begin
            d.regs[idx[2:0]] = merge(q.regs[idx[2:0]], avs_writedata,
                                     bem & REG_WMASK[idx[2:0]]);
        end

        // --------------------------------------------------------
        // Operating state
        // --------------------------------------------------------
        d.retry = '0;
        if (!q.sy2.input_power_good) begin
            d.st = ST_RESET;
            d.regs = REG_RST;
            d.prime = 2'b00;
        end else begin
            case (q.st)
                ST_RESET: begin
                    d.st = ST_SEQ_START;
                end
                ST_SEQ_START, ST_ACTIVE, ST_SLEEP: begin
                    if (th) begin
                        d.st = ST_THERMAL;
                    end else if (flt_go) begin
                        d.st = ST_RAIL_FAULT;
                    end else if (dp_go) begin
                        d.st = ST_DEEP;
                    end else if (sl_go) begin
                        d.st = ST_SLEEP;
                    end else begin
                        d.st = ST_ACTIVE;
                    end
                end
                ST_DEEP: begin
                    if (th | rail_flt) begin
                        d.st = ST_ACTIVE;
                        d.regs[CTRL_IDX][DP_ARM_BIT] = 1'b0;
                    end else if (!dp_go) begin
                        d.st = sl_go ? ST_SLEEP : ST_ACTIVE;
                    end
                end
                ST_THERMAL: begin
                    if (!th) begin
                        d.st = ST_SEQ_START;
                    end
                end
                ST_RAIL_FAULT: begin
                    d.retry = q.retry + RETRY_W'(1);
                    if (th) begin
                        d.st = ST_THERMAL;
                    end else if (q.retry == RETRY_W'(RETRY_CYCLES - 1)) begin
                        d.st = ST_ACTIVE;
                    end
                end
                default: begin
                    d.st = ST_RESET;
                end
            endcase
            // Arming by the pin wins over a clear in the same cycle
            if (rise) begin
                d.regs[CTRL_IDX][DP_ARM_BIT] = 1'b1;
            end
        end

        d.txn_rst = (d.st != q.st) & ((d.st == ST_SLEEP) | (d.st == ST_DEEP)
                  | (d.st == ST_THERMAL) | (d.st == ST_RAIL_FAULT));
        d.rst_out = (d.st == ST_ACTIVE) | (d.st == ST_SLEEP)
                  | (d.st == ST_DEEP);

        // --------------------------------------------------------
        // Rail enables
        // --------------------------------------------------------
        // Faults cut the rails at once, without sequencing delays
        off_all = (q.st == ST_RESET) | (q.st == ST_THERMAL)
                | (q.st == ST_RAIL_FAULT);
        for (int i = 0; i < NRAIL; i++) begin
            if (off_all) begin
                d.en[i] = 1'b0;
                d.dcnt[i] = '0;
            end else if (q.en[i] != tgt[i]) begin
                if (q.dcnt[i] >= lim[i]) begin
                    d.en[i] = tgt[i];
                    d.dcnt[i] = '0;
                end else begin
                    d.dcnt[i] = q.dcnt[i] + DCNT_W'(1);
                end
            end else begin
                d.dcnt[i] = '0;
            end
        end

        d.irq_n = ~((th & ~q.regs[MASK_IDX][TH_MASK_BIT])
                | (|(ov & ~q.regs[RMASK_IDX][OV_MASK_POS +: NRAIL]))
                | (|(uv & q.sy2.ramp_done
                     & ~q.regs[RMASK_IDX][UV_MASK_POS +: NRAIL])));
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.st <= ST_RESET;
            q.pin_prev <= 1'b1;
            q.regs <= REG_RST;
            q.irq_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    assign regulator_enable = q.en;
    assign reset_out_low = {NRST{q.rst_out}};
    assign interrupt_out_low = q.irq_n;
    assign serial_txn_reset = q.txn_rst;
    assign op_state = q.st;

endmodule

/* dv/rail_model.sv */
`timescale 1ns/100ps
module rail_model (
    input wire logic core_clk,
    input wire logic [pmic_state_pkg::NRAIL-1:0] regulator_enable,
    input wire logic power_good,
    input wire logic hot,
    input wire logic [pmic_state_pkg::NRAIL-1:0] ov_force,
    input wire logic [pmic_state_pkg::NRAIL-1:0] oc_force,
    output pmic_state_pkg::pmic_pins_t pins
);
    import pmic_state_pkg::*;
    // ------------------------------------------------------------
    // Rails and sensors
    // ------------------------------------------------------------
    logic [NRAIL-1:0] ramp1_q;
    logic [NRAIL-1:0] ramp2_q;
    // Ramp ends two cycles after enable, so early sag is ignored
    always_ff @(posedge core_clk) begin
        ramp1_q <= regulator_enable;
        ramp2_q <= ramp1_q & regulator_enable;
    end
    always_comb begin
        pins.input_power_good = power_good;
        pins.thermal_fault = hot;
        pins.over_voltage_fault = ov_force;
        pins.under_voltage_fault = oc_force;
        pins.ramp_done = ramp2_q;
    end
endmodule

/* dv/pmic_state_checker.sv */
`timescale 1ns/100ps
module pmic_state_checker #(
    parameter int unsigned RETRY_CYCLES = pmic_state_pkg::RETRY_CYC
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic power_enable_input,
    input wire logic [pmic_state_pkg::NRAIL-1:0] regulator_enable,
    input wire logic [pmic_state_pkg::NRST-1:0] reset_out_low,
    input wire logic serial_txn_reset,
    input wire pmic_state_pkg::op_state_t op_state
);
    import pmic_state_pkg::*;
    // ------------------------------------------------------------
    // Retry wait counter
    // ------------------------------------------------------------
    logic [23:0] rf_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rf_q <= 24'h0;
        end else begin
            rf_q <= (op_state == ST_RAIL_FAULT) ? rf_q + 24'h1 : 24'h0;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Two cycles allowed, rails may lag the state by one edge
    AST_RESET_OFF: assert property ((op_state == ST_RESET)[*2] |->
        regulator_enable == '0 && reset_out_low == '0) else $error("outputs up in reset");
    AST_THERM_OFF: assert property ((op_state == ST_THERMAL)[*2] |->
        regulator_enable == '0 && reset_out_low == '0) else $error("outputs up in thermal");
    AST_RF_OFF: assert property ((op_state == ST_RAIL_FAULT)[*2] |->
        regulator_enable == '0 && reset_out_low == '0) else $error("outputs up in fault");
    AST_TXN: assert property (serial_txn_reset == ($changed(op_state) &&
        op_state inside {ST_SLEEP, ST_DEEP, ST_THERMAL, ST_RAIL_FAULT}))
        else $error("serial reset pulse wrong");
    AST_RETRY_MAX: assert property (op_state == ST_RAIL_FAULT |->
        rf_q < RETRY_CYCLES) else $error("retry wait too long");
    // Fault state lasts exactly the retry count before moving to active
    AST_RETRY_MIN: assert property ($fell(op_state == ST_RAIL_FAULT) &&
        op_state == ST_ACTIVE |-> $past(rf_q) + 24'h1 == RETRY_CYCLES)
        else $error("retry wait wrong length");
    // Pin passes two flops, state moves on the third edge
    AST_DEEP_PIN: assert property ($rose(op_state == ST_DEEP) |->
        !$past(power_enable_input, 3)) else $error("deep entry with pin high");
    AST_SEQ: assert property ($fell(op_state == ST_RESET) |->
        op_state == ST_SEQ_START ##1 op_state != ST_SEQ_START) else $error("bad start");
endmodule
bind pmic_state_ctrl pmic_state_checker #(.RETRY_CYCLES(RETRY_CYCLES)) u_chk (
    .core_clk(core_clk), .arst_n(arst_n), .power_enable_input(power_enable_input),
    .regulator_enable(regulator_enable), .reset_out_low(reset_out_low),
    .serial_txn_reset(serial_txn_reset), .op_state(op_state));

/* dv/pmic_low_power_fault_state_control_test.sv */
`timescale 1ns/100ps
`define CK(n, e, s) begin total_checks++; if ((s) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module pmic_low_power_fault_state_control_test;
    import pmic_state_pkg::*;
    localparam int unsigned RT = 50;
    logic core_clk = 1'b0, arst_n = 1'b0, rd_q = 1'b0, wr_q = 1'b0, waitreq, txn, irq_n;
    logic pin = 1'b0, pg = 1'b0, hot = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdat = 32'h0, rdata, rdat, c, lp;
    logic [NRAIL-1:0] ov = 5'h0, oc = 5'h0, rails;
    logic [NRST-1:0] rst_n;
    pmic_pins_t pins;
    op_state_t op_state, st;
    int bad_count = 0, total_checks = 0, n, cyc_cnt = 0;
    always #50 core_clk = ~core_clk;
    pmic_state_ctrl #(.RETRY_CYCLES(RT), .DLY_UNIT(4)) DUT (.core_clk(core_clk),
        .arst_n(arst_n), .avs_address(addr), .avs_read(rd_q), .avs_write(wr_q),
        .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(waitreq), .power_enable_input(pin), .pins(pins),
        .regulator_enable(rails), .reset_out_low(rst_n), .interrupt_out_low(irq_n),
        .serial_txn_reset(txn), .op_state(op_state));
    rail_model u_rail (.core_clk(core_clk), .regulator_enable(rails), .power_good(pg),
        .hot(hot), .ov_force(ov), .oc_force(oc), .pins(pins));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Hang guard, whole run needs about 1700 cycles
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_q <= w;
        rd_q <= ~w;
        wdat <= d;
        // Request stands until waitrequest is seen low at a rising edge
        do @(posedge core_clk); while (waitreq !== 1'b0);
        rdat = rdata;
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask
    function automatic op_state_t exp_st(input logic [31:0] r, input logic p);
        if (!p && r[DP_ARM_BIT] && (r[DP_REQ_BIT] || r[DP_SEL_BIT])) return ST_DEEP;
        if (r[SLP_REQ_BIT] && r[SLP_ARM_BIT]) return ST_SLEEP;
        return ST_ACTIVE;
    endfunction
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h596d33c8));
        cyc(5);
        arst_n <= 1'b1;
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b0, 8'h00, 32'h0);
        `CK("ctrl", 32'h0, rdat)
        `CK("st", ST_RESET, op_state)
        pg <= 1'b1;
        cyc(8);
        `CK("st", ST_ACTIVE, op_state)
        `CK("rst", 3'h7, rst_n)
        bus(1'b0, 8'h1c, 32'h0);
        `CK("unmapped", 32'h0, rdat)
        lp = $urandom & 32'h1f1f;
        bus(1'b1, 8'h0c, lp);
        bus(1'b1, 8'h10, $urandom & 32'hfffff);
        bus(1'b1, 8'h14, $urandom & 32'hfffff);
        // Pin settles before the write so a pin rise cannot alter the arm bit
        for (int i = 0; i < 16; i++) begin
            pin <= 1'($urandom);
            cyc(4);
            c = $urandom & 32'h1f;
            bus(1'b1, 8'h00, c);
            cyc(70);
            st = exp_st(c, pin);
            `CK("st", st, op_state)
            `CK("rl", st == ST_SLEEP ? lp[4:0] : st == ST_DEEP ? lp[12:8] : 5'h1f, rails)
            bus(1'b0, 8'h00, 32'h0);
            `CK("ctrl", c, rdat)
        end
        bus(1'b1, 8'h00, 32'h10);
        pin <= 1'b0;
        cyc(4);
        pin <= 1'b1;
        cyc(4);
        bus(1'b0, 8'h00, 32'h0);
        `CK("arm", 1'b1, rdat[DP_ARM_BIT])
        pin <= 1'b0;
        cyc(6);
        `CK("st", ST_DEEP, op_state)
        bus(1'b1, 8'h00, 32'h38);
        ov <= 5'h01;
        cyc(6);
        `CK("st", ST_ACTIVE, op_state)
        `CK("irq", 1'b0, irq_n)
        bus(1'b0, 8'h00, 32'h0);
        `CK("arm", 1'b0, rdat[DP_ARM_BIT])
        cyc(20);
        `CK("st", ST_ACTIVE, op_state)
        bus(1'b1, 8'h00, 32'h10);
        bus(1'b1, 8'h08, 32'h1f1f);
        ov <= 5'h04;
        cyc(6);
        `CK("st", ST_RAIL_FAULT, op_state)
        `CK("irq", 1'b1, irq_n)
        n = 0;
        repeat (RT + 10) begin
            @(posedge core_clk);
            if (op_state === ST_ACTIVE) n++;
        end
        `CK("retry", 1'b1, n > 0)
        `CK("st", ST_RAIL_FAULT, op_state)
        ov <= 5'h0;
        cyc(RT + 10);
        `CK("st", ST_ACTIVE, op_state)
        cyc(80);
        oc <= 5'h02;
        cyc(6);
        `CK("st", ST_RAIL_FAULT, op_state)
        oc <= 5'h0;
        cyc(RT + 10);
        bus(1'b1, 8'h04, 32'h20);
        hot <= 1'b1;
        cyc(6);
        `CK("st", ST_THERMAL, op_state)
        `CK("irq", 1'b1, irq_n)
        hot <= 1'b0;
        cyc(8);
        `CK("st", ST_ACTIVE, op_state)
        pg <= 1'b0;
        cyc(6);
        `CK("st", ST_RESET, op_state)
        bus(1'b0, 8'h04, 32'h0);
        `CK("mask", 32'h0, rdat)
        end_sim();
    end
endmodule
